// *** prs_map.svh ***
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 32-bit register port, byte offsets, one aligned word per register
// Notes: definitions only
`ifndef PRS_MAP_SVH
`define PRS_MAP_SVH
// register byte offsets
`define PRS_A_SRST 8'h00
`define PRS_A_STBY 8'h04
`define PRS_A_ENCFG 8'h08
`define PRS_A_SEREN 8'h0C
`define PRS_A_UVW 8'h10
`define PRS_A_UVF 8'h14
`define PRS_A_SUPPLY_INPUT_ONE 8'h18
`define PRS_A_SUPPLY_INPUT_TWO 8'h1C
`define PRS_A_TEMP 8'h20
`define PRS_A_THERM 8'h24
`define PRS_A_FLAG 8'h28
`define PRS_A_RUN 8'h2C
`define PRS_A_GPIN 8'h50
// per-channel groups: upper address nibble, channel in bits [3:2]
`define PRS_A_TGT_HI 4'h3
`define PRS_A_VOUT_HI 4'h4
// standby regulator config fields
`define PRS_STBY_5V 0
`define PRS_STBY_SER 1
`define PRS_STBY_GP 2
`define PRS_STBY_PIN 3
// enable config fields (bits [7:0] hold a 2-bit mode per channel)
`define PRS_EC_SERIAL 8
`define PRS_EC_UVAUTO 9
`define PRS_EC_OTAUTO 10
`define PRS_EC_OTW10 11
`define PRS_EC_UVWPIN 12
// protection flag fields
`define PRS_FL_UVF 0
`define PRS_FL_UVW 2
`define PRS_FL_OTW 4
`define PRS_FL_OTF 5
`define PRS_FL_OVP 6
`define PRS_FL_OCP 10
// reset (start-up default) values
`define PRS_STBY_RST 4'h8
`define PRS_ENCFG_RST 16'h0000
`define PRS_UVW_RST 16'h4141
`define PRS_UVF_RST 16'h3C3C
`define PRS_TSHD_RST 7'h4B
`define PRS_TRST_RST 7'h46
`define PRS_TGT_RST 8'h00
// temperature warning offsets in 5 K codes
`define PRS_OTW_5K 8'h01
`define PRS_OTW_10K 8'h02
// pin assignments
`define PRS_STBY_GPIO 2
`define PRS_WARN_GPIO 3
// timing
`define PRS_CLK_HZ 20000000
`define PRS_OCP_MS 200
`define PRS_OCP_CYC ((`PRS_CLK_HZ / 1000) * `PRS_OCP_MS)
`define PRS_DEAD_NS 50
`define PRS_DEAD_CYC ((`PRS_DEAD_NS * (`PRS_CLK_HZ / 1000000) + 999) / 1000)
`define PRS_LDO_CYC 4'h4
`define PRS_CFG_CYC 4'h8
`endif

// *** prs_pkg.sv ***
// Purpose: types shared by the supervisor
// Assumes: nothing
// Notes: offsets and counts live in prs_map.svh
package prs_pkg;
  typedef enum logic [1:0] {
    PH_OFF = 2'b00,
    PH_LDO = 2'b01,
    PH_CFG = 2'b10,
    PH_READY = 2'b11
  } prs_phase_t;
  typedef enum logic [1:0] {
    MODE_SERIAL = 2'b00,
    MODE_ALWAYS = 2'b01,
    MODE_GPIO = 2'b10,
    MODE_OFF = 2'b11
  } prs_mode_t;
endpackage

// *** prs_gate_drv.sv ***
// Purpose: non-overlapping high/low side drive for one channel
// Assumes: i_pwm from the modulator on the same clock
// Notes: DEAD+1 cycles with both drives off at every change
`timescale 1ns/100ps
`include "prs_map.svh"
module prs_gate_drv #(
  parameter int unsigned DEAD = `PRS_DEAD_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_en,
  input wire logic i_pwm,
  output logic o_hs,
  output logic o_ls
);
  localparam int unsigned CW = $clog2(DEAD + 1);
  logic [CW-1:0] gap_q;
  logic want_hs;
  logic want_ls;

  assign want_hs = i_en & i_pwm;
  assign want_ls = i_en & ~i_pwm;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_hs <= 1'b0;
      o_ls <= 1'b0;
      gap_q <= '0;
    end else if ((o_hs & ~want_hs) | (o_ls & ~want_ls)) begin
      o_hs <= 1'b0; // drop first, the other side waits out the gap
      o_ls <= 1'b0;
      gap_q <= CW'(DEAD);
    end else if (gap_q != '0) begin
      gap_q <= gap_q - CW'(1);
    end else begin
      o_hs <= want_hs & ~o_ls;
      o_ls <= want_ls & ~o_hs;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  drive_overlap_a: assert property (!(o_hs && o_ls))
    else $error("both gate drives on");
  low_gap_a: assert property ($fell(o_ls) |-> !o_hs [*2])
    else $error("high side on inside the gap after low side");
  high_gap_a: assert property ($fell(o_hs) |-> !o_ls [*2])
    else $error("low side on inside the gap after high side");
endmodule // prs_gate_drv

// *** prs_supervisor.sv ***
// Purpose: power-up phases, enables and fault supervision of a four-channel buck controller
// Assumes: measurement codes, trip comparators and pwm come from logic on i_clk
// Notes: enable pin and gpio pins are asynchronous and pass two flops
`timescale 1ns/100ps
`include "prs_map.svh"
module prs_supervisor #(
  parameter int unsigned NCH = 4,
  parameter int unsigned OCP_WAIT = `PRS_OCP_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_enable_pin,
  input wire logic [5:0] i_gpio,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_supply_input_one_code,
  input wire logic [7:0] i_supply_input_two_code,
  input wire logic [6:0] i_temp_code,
  input wire logic [NCH*8-1:0] i_vout_code,
  input wire logic [NCH-1:0] i_ovp_trip,
  input wire logic [NCH-1:0] i_ocp_trip,
  input wire logic [NCH-1:0] i_pwm,
  output logic [31:0] o_rdata,
  output logic o_ready,
  output logic [NCH-1:0] o_ch_run,
  output logic [NCH-1:0] o_hs_drv,
  output logic [NCH-1:0] o_ls_drv,
  output logic [NCH*16-1:0] o_target_mv,
  output logic o_stby_on,
  output logic o_stby_5v,
  output logic [5:0] o_gpio_o,
  output logic [5:0] o_gpio_oe
);
  localparam int unsigned CW = $clog2(OCP_WAIT + 1);

  // millivolts of a 50 mV target code
  function automatic logic [15:0] mv50(input logic [7:0] code);
    mv50 = 16'({8'h00, code} * 16'h0032);
  endfunction

  logic srst_q;
  logic rst_all;
  logic en_s1_q;
  logic en_s2_q;
  logic [5:0] gp_s1_q;
  logic [5:0] gp_s2_q;
  prs_pkg::prs_phase_t ph_q;
  prs_pkg::prs_phase_t ph_d;
  logic [3:0] ph_cnt_q;
  logic wr_ok;
  logic [3:0] stby_q;
  logic [15:0] encfg_q;
  logic [NCH-1:0] seren_q;
  logic [15:0] uvw_q;
  logic [15:0] uvf_q;
  logic [6:0] tshd_q;
  logic [6:0] trst_q;
  logic [7:0] tgt_q [NCH];
  logic [1:0] uv_flt;
  logic [1:0] uv_warn;
  logic uv_clr;
  logic uv_shut_q;
  logic ot_flt;
  logic ot_warn;
  logic ot_shut_q;
  logic [7:0] otw_off;
  logic [NCH-1:0] ovp_lat_q;
  logic [CW-1:0] ocp_cnt_q [NCH];
  logic [NCH-1:0] ocp_wait;
  logic [NCH-1:0] src;
  logic [NCH-1:0] run_d;
  logic [13:0] flags;
  logic [5:0] gp_vis;
  logic [31:0] rd_d;

  // a soft reset acts like the power-up reset on everything below except the soft reset flop and the synchronisers
  assign rst_all = i_rst | srst_q;

  // two-flop synchronisers for the pins
  always_ff @(posedge i_clk) begin
    en_s1_q <= i_enable_pin;
    en_s2_q <= en_s1_q;
    gp_s1_q <= i_gpio;
    gp_s2_q <= gp_s1_q;
  end

  always_comb begin
    ph_d = ph_q;
    unique case (ph_q)
      prs_pkg::PH_OFF: begin
        if (en_s2_q) begin
          ph_d = prs_pkg::PH_LDO;
        end
      end
      prs_pkg::PH_LDO: begin
        if (ph_cnt_q == `PRS_LDO_CYC) begin
          ph_d = prs_pkg::PH_CFG;
        end
      end
      prs_pkg::PH_CFG: begin
        if (ph_cnt_q == `PRS_CFG_CYC) begin
          ph_d = prs_pkg::PH_READY;
        end
      end
      prs_pkg::PH_READY: begin
        ph_d = prs_pkg::PH_READY;
      end
    endcase
    if (!en_s2_q) begin
      ph_d = prs_pkg::PH_OFF;
    end
  end

  // phase register and dwell counter, restarted at every phase change
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      ph_q <= prs_pkg::PH_OFF;
      ph_cnt_q <= 4'h0;
    end else begin
      ph_q <= ph_d;
      ph_cnt_q <= (ph_d != ph_q) ? 4'h0 : ph_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      o_ready <= 1'b0;
    end else begin
      o_ready <= (ph_d == prs_pkg::PH_READY);
    end
  end

  assign wr_ok = i_wr & o_ready;

  // soft reset pulse, clears itself after one cycle; reset only by the pin-level reset path
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= wr_ok & (i_addr == `PRS_A_SRST) & i_wdata[0] & ~srst_q;
    end
  end

  // configuration written by the host, defaults from start-up memory
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      stby_q <= `PRS_STBY_RST;
      encfg_q <= `PRS_ENCFG_RST;
      seren_q <= '0;
      uvw_q <= `PRS_UVW_RST;
      uvf_q <= `PRS_UVF_RST;
      tshd_q <= `PRS_TSHD_RST;
      trst_q <= `PRS_TRST_RST;
    end else if (wr_ok) begin
      if (i_addr == `PRS_A_STBY) begin
        stby_q <= i_wdata[3:0];
      end
      if (i_addr == `PRS_A_ENCFG) begin
        encfg_q <= i_wdata[15:0];
      end
      if (i_addr == `PRS_A_SEREN) begin
        seren_q <= i_wdata[NCH-1:0];
      end
      if (i_addr == `PRS_A_UVW) begin
        uvw_q <= i_wdata[15:0];
      end
      if (i_addr == `PRS_A_UVF) begin
        uvf_q <= i_wdata[15:0];
      end
      if (i_addr == `PRS_A_THERM) begin
        tshd_q <= i_wdata[6:0];
        trst_q <= i_wdata[14:8];
      end
    end
  end

  // per-channel target codes and millivolt targets
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      for (int c = 0; c < NCH; c++) begin
        tgt_q[c] <= `PRS_TGT_RST;
        o_target_mv[c*16 +: 16] <= mv50(`PRS_TGT_RST);
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (wr_ok && i_addr[7:4] == `PRS_A_TGT_HI && i_addr[3:2] == 2'(c) && i_addr[1:0] == 2'h0) begin
          tgt_q[c] <= i_wdata[7:0];
        end
        o_target_mv[c*16 +: 16] <= mv50(tgt_q[c]);
      end
    end
  end

  // input comparisons, codes at 100 mV
  assign uv_flt = {i_supply_input_two_code < uvf_q[15:8], i_supply_input_one_code < uvf_q[7:0]};
  assign uv_warn = {i_supply_input_two_code < uvw_q[15:8], i_supply_input_one_code < uvw_q[7:0]};
  assign uv_clr = (i_supply_input_one_code > uvw_q[7:0]) & (i_supply_input_two_code > uvw_q[15:8]);

  // under-voltage lockout: set wins, auto clear above warning
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      uv_shut_q <= 1'b0;
    end else if (|uv_flt) begin
      uv_shut_q <= 1'b1;
    end else if (encfg_q[`PRS_EC_UVAUTO] && uv_clr) begin
      uv_shut_q <= 1'b0;
    end
  end

  // warning 1 or 2 codes early
  assign otw_off = encfg_q[`PRS_EC_OTW10] ? `PRS_OTW_10K : `PRS_OTW_5K;
  assign ot_flt = (i_temp_code >= tshd_q);
  assign ot_warn = ({1'b0, i_temp_code} + otw_off) >= {1'b0, tshd_q};

  // thermal shutdown, optional restart at restart level
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      ot_shut_q <= 1'b0;
    end else if (ot_flt) begin
      ot_shut_q <= 1'b1;
    end else if (encfg_q[`PRS_EC_OTAUTO] && i_temp_code <= trst_q) begin
      ot_shut_q <= 1'b0;
    end
  end

  // over-voltage latch, cleared by a serial re-enable, set wins
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      ovp_lat_q <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (i_ovp_trip[c] && o_ch_run[c]) begin
          ovp_lat_q[c] <= 1'b1;
        end else if (wr_ok && i_addr == `PRS_A_SEREN && i_wdata[c]) begin
          ovp_lat_q[c] <= 1'b0;
        end
      end
    end
  end

  // over-current hold-off; long count, shorten OCP_WAIT in simulation
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      for (int c = 0; c < NCH; c++) begin
        ocp_cnt_q[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (i_ocp_trip[c] && o_ch_run[c]) begin
          ocp_cnt_q[c] <= CW'(OCP_WAIT);
        end else if (ocp_cnt_q[c] != '0) begin
          ocp_cnt_q[c] <= ocp_cnt_q[c] - CW'(1);
        end
      end
    end
  end

  // enable sources per channel; in gpio mode channel c follows gpio c or its serial enable
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      ocp_wait[c] = (ocp_cnt_q[c] != '0);
      unique case (prs_pkg::prs_mode_t'(encfg_q[2*c +: 2]))
        prs_pkg::MODE_ALWAYS: src[c] = 1'b1;
        prs_pkg::MODE_GPIO: src[c] = gp_s2_q[c] | seren_q[c];
        prs_pkg::MODE_SERIAL: src[c] = seren_q[c];
        prs_pkg::MODE_OFF: src[c] = 1'b0;
      endcase
    end
  end

  assign run_d = (o_ready && !uv_shut_q && !ot_shut_q && !(|uv_flt) && !ot_flt)
               ? (src & ~ovp_lat_q & ~ocp_wait & ~i_ovp_trip & ~i_ocp_trip) : '0;

  // channel run flags, released to the gate drivers
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      o_ch_run <= '0;
    end else begin
      o_ch_run <= run_d;
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_drv
    prs_gate_drv #(
      .DEAD(`PRS_DEAD_CYC)
    ) u_drv (
      .i_clk(i_clk),
      .i_rst(rst_all),
      .i_en(o_ch_run[g]),
      .i_pwm(i_pwm[g]),
      .o_hs(o_hs_drv[g]),
      .o_ls(o_ls_drv[g])
    );
  end

  // standby regulator: pin, gpio or serial, runs before ready too
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      o_stby_on <= 1'b0;
      o_stby_5v <= 1'b0;
    end else begin
      o_stby_on <= (stby_q[`PRS_STBY_PIN] & en_s2_q) | (stby_q[`PRS_STBY_GP] & gp_s2_q[`PRS_STBY_GPIO])
                 | stby_q[`PRS_STBY_SER];
      o_stby_5v <= stby_q[`PRS_STBY_5V];
    end
  end

  // optional warning pin; pins 4 and 5 left to the serial slave
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      o_gpio_o <= '0;
      o_gpio_oe <= '0;
    end else begin
      o_gpio_o <= '0;
      o_gpio_oe <= '0;
      o_gpio_o[`PRS_WARN_GPIO] <= |uv_warn;
      o_gpio_oe[`PRS_WARN_GPIO] <= encfg_q[`PRS_EC_UVWPIN];
    end
  end

  // in serial mode pins 4 and 5 read as zero through the gpio register
  assign gp_vis = encfg_q[`PRS_EC_SERIAL] ? {2'b00, gp_s2_q[3:0]} : gp_s2_q;

  // flag word; the thermal warning bit always carries the thermal fault
  assign flags = {ocp_wait, ovp_lat_q, ot_flt, ot_warn | ot_flt, uv_warn, uv_flt};

  // read mux; flags have no write path
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (i_addr)
      `PRS_A_STBY: rd_d[3:0] = stby_q;
      `PRS_A_ENCFG: rd_d[15:0] = encfg_q;
      `PRS_A_SEREN: rd_d[NCH-1:0] = seren_q;
      `PRS_A_UVW: rd_d[15:0] = uvw_q;
      `PRS_A_UVF: rd_d[15:0] = uvf_q;
      `PRS_A_SUPPLY_INPUT_ONE: rd_d[7:0] = i_supply_input_one_code;
      `PRS_A_SUPPLY_INPUT_TWO: rd_d[7:0] = i_supply_input_two_code;
      `PRS_A_TEMP: rd_d[6:0] = i_temp_code;
      `PRS_A_THERM: rd_d[14:0] = {trst_q, 1'b0, tshd_q};
      `PRS_A_FLAG: rd_d[13:0] = flags;
      `PRS_A_RUN: rd_d[NCH-1:0] = o_ch_run;
      `PRS_A_GPIN: rd_d[5:0] = gp_vis;
      default: begin
        // target and measured output per channel
        if (i_addr[1:0] == 2'h0 && i_addr[7:4] == `PRS_A_TGT_HI) begin
          rd_d[7:0] = tgt_q[i_addr[3:2]];
        end else if (i_addr[1:0] == 2'h0 && i_addr[7:4] == `PRS_A_VOUT_HI) begin
          rd_d[7:0] = i_vout_code[i_addr[3:2]*8 +: 8];
        end
      end
    endcase
  end

  // read data only in the cycle after an accepted read
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      o_rdata <= (i_rd && o_ready) ? rd_d : 32'h0000_0000;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (rst_all);

  sequence early_write_s;
    i_wr && !o_ready && i_addr == `PRS_A_SEREN;
  endsequence
  sequence ocp_trip_s;
    i_ocp_trip[0] && o_ch_run[0];
  endsequence

  not_ready_a: assert property (early_write_s |=> seren_q == $past(seren_q))
    else $error("write taken before ready");
  always_on_a: assert property (o_ready && encfg_q[1:0] == 2'b01 && !uv_shut_q && !ot_shut_q
    && !(|uv_flt) && !ot_flt && !ovp_lat_q[0] && !ocp_wait[0] && !i_ovp_trip[0] && !i_ocp_trip[0]
    |=> o_ch_run[0])
    else $error("always-on channel not running");
  pin_low_a: assert property (!en_s2_q |=> !o_ready ##1 !(|o_ch_run))
    else $error("chip still ready after enable pin low");
  soft_reset_a: assert property (disable iff (i_rst) wr_ok && !srst_q && i_addr == `PRS_A_SRST && i_wdata[0]
    |=> srst_q ##1 ph_q == prs_pkg::PH_OFF)
    else $error("soft reset did not restart phases");
  uv_shutdown_a: assert property (|uv_flt |=> o_ch_run == '0 && uv_shut_q)
    else $error("channels run through under-voltage");
  ot_both_a: assert property (ot_flt |-> flags[`PRS_FL_OTF] && flags[`PRS_FL_OTW] ##1 o_ch_run == '0)
    else $error("thermal fault bits or shutdown missing");
  ovp_shut_a: assert property (i_ovp_trip[1] && o_ch_run[1] |=> !o_ch_run[1] && ovp_lat_q[1])
    else $error("over-voltage channel not shut");
  ocp_hold_a: assert property (ocp_trip_s |=> !o_ch_run[0] [*2])
    else $error("over-current channel restarted early");
  target_mv_a: assert property (1'b1 |=> o_target_mv[15:0] == 16'($past(tgt_q[0]) * 50))
    else $error("target millivolts wrong");
endmodule // prs_supervisor

// *** prs_host_model.sv ***
// Purpose: host controller model driving the register port of the supervisor
// Assumes: register port stands for the serial slave, no wait states
// Notes: address is scrambled once a strobe drops, write data once the write strobe drops
`timescale 1ns/100ps
module prs_host_model (
  input wire logic i_clk,
  input wire logic [31:0] i_rdata,
  output logic [7:0] o_addr,
  output logic [31:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  localparam logic [7:0] DIV_CODE = 8'h32;
  // idle bus at time zero
  initial begin
    o_addr = 8'h00;
    o_wdata = 32'h0;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  function automatic logic [7:0] legal_code(logic [7:0] c);
    return (c > 8'h32) ? {c[7:1], 1'b0} : c;
  endfunction
  // one-cycle write; stale address is inverted so the slave cannot lean on it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  // one-cycle read, data taken in the cycle after the strobe only
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    @(posedge i_clk);
    d = i_rdata;
  endtask
endmodule // prs_host_model

// *** prs_supervisor_tb_top.sv ***
// Purpose: self-checking bench for the supervisor
// Assumes: host model owns the register port
// Notes: over-current wait shortened to OCP_W cycles to keep the run short
`timescale 1ns/100ps
`include "prs_map.svh"
module prs_supervisor_tb_top;
  localparam int OCP_W = 20;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_enable_pin = 1'b0;
  logic [5:0] i_gpio = 6'h00;
  logic [7:0] i_addr, i_supply_input_one_code = 8'h50, i_supply_input_two_code = 8'h50, code;
  logic [31:0] i_wdata, o_rdata, i_vout_code = 32'h0;
  logic i_wr, i_rd, o_ready, o_stby_on, o_stby_5v;
  logic [6:0] i_temp_code = 7'h20;
  logic [3:0] i_ovp_trip = 4'h0, i_ocp_trip = 4'h0, i_pwm = 4'h0, o_ch_run, o_hs_drv, o_ls_drv;
  logic [3:0] prev_hs = 4'h0, prev_ls = 4'h0, md, sn;
  logic [63:0] o_target_mv;
  logic [5:0] o_gpio_o, o_gpio_oe;
  logic [7:0] cyc = 8'h00;
  int n_fail = 0, compares = 0;

  prs_supervisor #(.OCP_WAIT(OCP_W)) prs_supervisor_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_enable_pin(i_enable_pin), .i_gpio(i_gpio), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_supply_input_one_code(i_supply_input_one_code), .i_supply_input_two_code(i_supply_input_two_code),
    .i_temp_code(i_temp_code), .i_vout_code(i_vout_code), .i_ovp_trip(i_ovp_trip), .i_ocp_trip(i_ocp_trip),
    .i_pwm(i_pwm), .o_rdata(o_rdata), .o_ready(o_ready), .o_ch_run(o_ch_run), .o_hs_drv(o_hs_drv),
    .o_ls_drv(o_ls_drv), .o_target_mv(o_target_mv), .o_stby_on(o_stby_on), .o_stby_5v(o_stby_5v),
    .o_gpio_o(o_gpio_o), .o_gpio_oe(o_gpio_oe));
  prs_host_model prs_host_model_i (.i_clk(i_clk), .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata),
    .o_wr(i_wr), .o_rd(i_rd));

  // 20 MHz clock
  always #25 i_clk = ~i_clk;

  // expected run vector from modes, serial enables and pins
  function automatic logic [3:0] exp_run(logic [7:0] m, logic [3:0] s, logic [3:0] g);
    for (int c = 0; c < 4; c++) begin
      case (m[2*c +: 2])
        2'b00: exp_run[c] = s[c];
        2'b01: exp_run[c] = 1'b1;
        2'b10: exp_run[c] = g[c] | s[c];
        default: exp_run[c] = 1'b0;
      endcase
    end
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_rd(string n, logic [7:0] a, logic [31:0] e);
    logic [31:0] d;
    prs_host_model_i.rd(a, d);
    chk(n, e, d);
  endtask
  task automatic tk(int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic wait_ready();
    for (int k = 0; k < 200 && o_ready !== 1'b1; k++) @(posedge i_clk);
    chk("ready", 32'h1, o_ready);
  endtask
  task automatic done(string n);
    $display("end of test %s, mismatches so far %0d", n, n_fail);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // pwm stirred every 8 cycles; drives checked against overlap each edge
  always @(posedge i_clk) begin
    cyc <= cyc + 8'h01;
    if (cyc[2:0] == 3'h0) i_pwm <= 4'($urandom);
    if (!i_rst) chk("gate", 32'h0, {o_hs_drv & o_ls_drv, prev_hs & o_ls_drv, prev_ls & o_hs_drv});
    prev_hs <= o_hs_drv;
    prev_ls <= o_ls_drv;
  end

  // watchdog, far beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    close_out();
  end

  initial begin
    void'($urandom(62591));
    tk(10);
    i_rst <= 1'b0;
    prs_host_model_i.wr(`PRS_A_SEREN, 32'h0000_000F);
    chk_rd("early read", `PRS_A_STBY, 32'h0);
    chk("run early", 32'h0, o_ch_run);
    i_enable_pin <= 1'b1;
    wait_ready();
    chk_rd("dropped write", `PRS_A_SEREN, 32'h0);
    chk_rd("stby rst", `PRS_A_STBY, `PRS_STBY_RST);
    chk_rd("uvw rst", `PRS_A_UVW, `PRS_UVW_RST);
    chk_rd("uvf rst", `PRS_A_UVF, `PRS_UVF_RST);
    chk_rd("therm rst", `PRS_A_THERM, {`PRS_TRST_RST, 1'b0, `PRS_TSHD_RST});
    chk_rd("unmapped", 8'h60, 32'h0);
    done("reset values");
    chk("stby", 32'h1, {o_stby_5v, o_stby_on});
    prs_host_model_i.wr(`PRS_A_STBY, 32'h1);
    tk(2);
    chk("stby", 32'h2, {o_stby_5v, o_stby_on});
    prs_host_model_i.wr(`PRS_A_STBY, 32'h2);
    tk(2);
    chk("stby", 32'h1, {o_stby_5v, o_stby_on});
    i_gpio <= 6'h04;
    prs_host_model_i.wr(`PRS_A_STBY, 32'h4);
    tk(2);
    chk("stby gpio", 32'h1, {o_stby_5v, o_stby_on});
    done("standby");
    for (int i = 0; i < 8; i++) begin
      md = 4'($urandom);
      sn = 4'($urandom);
      code = (i == 0) ? 8'hE4 : 8'($urandom);
      i_gpio <= {2'b00, md};
      prs_host_model_i.wr(`PRS_A_ENCFG, {24'h0, code});
      prs_host_model_i.wr(`PRS_A_SEREN, {28'h0, sn});
      tk(5);
      chk("run", exp_run(code, sn, md), o_ch_run);
    end
    done("enable sources");
    for (int i = 0; i < 4; i++) begin
      i_supply_input_one_code <= 8'($urandom_range(8'hFF, 8'h42));
      i_supply_input_two_code <= 8'($urandom_range(8'hFF, 8'h42));
      i_temp_code <= 7'($urandom_range(8'h48, 8'h00));
      i_vout_code <= $urandom;
      code = (i == 3) ? prs_host_model_i.DIV_CODE : prs_host_model_i.legal_code(8'($urandom));
      prs_host_model_i.wr({`PRS_A_TGT_HI, 2'(i), 2'b00}, {24'h0, code});
      tk(2);
      chk("target mv", {8'h00, code} * 16'h0032, o_target_mv[16*i +: 16]);
      chk_rd("vout", {`PRS_A_VOUT_HI, 2'(i), 2'b00}, {24'h0, i_vout_code[8*i +: 8]});
      chk_rd("supply_input_one", `PRS_A_SUPPLY_INPUT_ONE, {24'h0, i_supply_input_one_code});
      chk_rd("supply_input_two", `PRS_A_SUPPLY_INPUT_TWO, {24'h0, i_supply_input_two_code});
      chk_rd("temp", `PRS_A_TEMP, {25'h0, i_temp_code});
    end
    prs_host_model_i.wr(`PRS_A_FLAG, 32'h0000_FFFF);
    chk_rd("flags ro", `PRS_A_FLAG, 32'h0);
    done("readback");
    i_supply_input_one_code <= 8'h50;
    i_supply_input_two_code <= 8'h50;
    i_temp_code <= 7'h20;
    prs_host_model_i.wr(`PRS_A_ENCFG, 32'h0000_1255);
    i_supply_input_one_code <= 8'h3E;
    tk(3);
    chk_rd("uv warn", `PRS_A_FLAG, 32'h4);
    chk("warn pin", 32'h208, {o_gpio_oe, o_gpio_o});
    chk("run", 32'hF, o_ch_run);
    i_supply_input_two_code <= 8'h3B;
    tk(3);
    chk_rd("uv fault", `PRS_A_FLAG, 32'hE);
    chk("run", 32'h0, o_ch_run);
    i_supply_input_one_code <= 8'h50;
    i_supply_input_two_code <= 8'h41;
    tk(4);
    chk("run", 32'h0, o_ch_run);
    i_supply_input_two_code <= 8'h42;
    tk(4);
    chk("run", 32'hF, o_ch_run);
    done("under-voltage");
    prs_host_model_i.wr(`PRS_A_ENCFG, 32'h0000_0655);
    i_temp_code <= 7'h4A;
    tk(3);
    chk_rd("ot warn 5", `PRS_A_FLAG, 32'h10);
    i_temp_code <= 7'h49;
    tk(3);
    chk_rd("ot warn 5", `PRS_A_FLAG, 32'h0);
    prs_host_model_i.wr(`PRS_A_ENCFG, 32'h0000_0E55);
    tk(3);
    chk_rd("ot warn 10", `PRS_A_FLAG, 32'h10);
    i_temp_code <= 7'h4B;
    tk(3);
    chk_rd("ot fault", `PRS_A_FLAG, 32'h30);
    chk("run", 32'h0, o_ch_run);
    i_temp_code <= 7'h47;
    tk(3);
    chk("run", 32'h0, o_ch_run);
    i_temp_code <= 7'h46;
    tk(4);
    chk("run", 32'hF, o_ch_run);
    prs_host_model_i.wr(`PRS_A_THERM, 32'hFFFF_FFFF);
    chk_rd("therm", `PRS_A_THERM, 32'h0000_7F7F);
    prs_host_model_i.wr(`PRS_A_THERM, 32'h0000_464B);
    i_temp_code <= 7'h20;
    done("temperature");
    i_ovp_trip <= 4'h2;
    tk(1);
    i_ovp_trip <= 4'h0;
    tk(3);
    chk("run", 32'hD, o_ch_run);
    chk_rd("ovp flag", `PRS_A_FLAG, 32'h80);
    prs_host_model_i.wr(`PRS_A_SEREN, 32'h2);
    tk(3);
    chk("run", 32'hF, o_ch_run);
    i_ocp_trip <= 4'h1;
    tk(1);
    i_ocp_trip <= 4'h0;
    chk_rd("ocp flag", `PRS_A_FLAG, 32'h400);
    tk(OCP_W - 6);
    chk("run", 32'hE, o_ch_run);
    tk(6);
    chk("run", 32'hF, o_ch_run);
    done("channel faults");
    i_gpio <= 6'h3F;
    prs_host_model_i.wr(`PRS_A_ENCFG, 32'h0000_0155);
    tk(4);
    chk_rd("gpio serial", `PRS_A_GPIN, 32'hF);
    prs_host_model_i.wr(`PRS_A_ENCFG, 32'h0000_0055);
    chk_rd("gpio plain", `PRS_A_GPIN, 32'h3F);
    i_enable_pin <= 1'b0;
    tk(5);
    chk("off", 32'h0, {o_ready, o_ch_run});
    i_enable_pin <= 1'b1;
    wait_ready();
    prs_host_model_i.wr(`PRS_A_STBY, 32'h1);
    prs_host_model_i.wr(`PRS_A_SRST, 32'h1);
    tk(3);
    wait_ready();
    chk_rd("stby after sr", `PRS_A_STBY, `PRS_STBY_RST);
    chk_rd("encfg after sr", `PRS_A_ENCFG, `PRS_ENCFG_RST);
    done("enable pin and soft reset");
    close_out();
  end
endmodule // prs_supervisor_tb_top
